// ### src/urp_cmd.sv
// Set and clear read-hide command interpreter of the tag.
`timescale 1ns/1ps
module urp_cmd #(
  parameter int REPLY_CYC = urp_pkg::REPLY_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  urp_pkg::urp_rx_t           rx,
  input  urp_pkg::urp_ctx_t          ctx,
  input  wire logic                  cfg_load,
  input  wire logic                  cfg_epc_hide,
  input  wire logic                  cfg_ident_hide,
  input  wire logic                  nvm_done,
  input  wire logic                  nvm_err,
  input  wire logic                  bs_bit_en,
  output logic                       epc_hide_flag_q,
  output logic                       ident_hide_flag_q,
  output logic                       st_upd_q,
  output urp_pkg::urp_g2_state_t     st_next_q,
  output logic                       nvm_req_q,
  output logic                       nvm_val_q,
  output urp_pkg::urp_bs_t           bs_q,
  output logic                       busy_q
);
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_NVM   = 2'b01,
    S_REPLY = 2'b10
  } urp_fsm_t;

  urp_fsm_t    st_q;
  urp_fsm_t    st_d;
  logic [79:0] sh_q;
  logic [6:0]  len_q;
  logic        armed_q;
  logic        set_q;
  logic        ok_q;
  logic [18:0] tmo_q;
  logic [15:0] rx_crc;
  logic        tx_busy;
  logic        tx_done;

  // Bits only count after a frame-sync; anything else is line noise.
  wire rx_take = armed_q && rx.valid;
  wire frame   = armed_q && rx.fend && (st_q == S_IDLE);

  wire is_set  = (len_q == urp_pkg::LEN_SET) && (sh_q[47:32] == urp_pkg::OP_SET);
  wire is_clr  = (len_q == urp_pkg::LEN_CLR) && (sh_q[79:64] == urp_pkg::OP_CLR);
  wire crc_ok  = (rx_crc == urp_pkg::CRC_RESIDUE);
  wire hnd_ok  = (sh_q[31:16] == ctx.handle);
  // The cover code uses the RN16 that the last Req_RN handed out.
  wire clr_pw_ok = ((sh_q[63:32] ^ {ctx.rn16, ctx.rn16}) == ctx.access_pw);
  wire pw_zero   = (ctx.access_pw == 32'h0);
  wire in_access = (ctx.state == urp_pkg::G2_OPEN) || (ctx.state == urp_pkg::G2_SECURED);
  wire secured   = (ctx.state == urp_pkg::G2_SECURED);
  wire cmd_hit   = frame && crc_ok && (is_set || is_clr);
  wire tmo_hit   = (tmo_q == 19'(REPLY_CYC - 1));

  logic                   dec_exec;
  logic                   dec_upd;
  urp_pkg::urp_g2_state_t dec_next;

  always_comb begin
    dec_exec = 1'b0;
    dec_upd  = 1'b0;
    dec_next = ctx.state;
    if (cmd_hit) begin
      if ((is_set && !secured) || (is_clr && !in_access)) begin
        // Silent in every other state; only the inventory states fall back.
        dec_upd = (ctx.state == urp_pkg::G2_ARBITRATE) || (ctx.state == urp_pkg::G2_REPLY) ||
                  (ctx.state == urp_pkg::G2_ACK);
        dec_next = dec_upd ? urp_pkg::G2_ARBITRATE : ctx.state;
      end else if (is_set && pw_zero) begin
        dec_upd = 1'b0;
      end else if (!hnd_ok) begin
        dec_upd = 1'b0;
      end else if (is_set ? !ctx.pw_auth : !clr_pw_ok) begin
        dec_upd  = 1'b1;
        dec_next = urp_pkg::G2_ARBITRATE;
      end else begin
        dec_exec = 1'b1;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (dec_exec) begin
          st_d = S_NVM;
        end
      end
      S_NVM: begin
        if (nvm_done || nvm_err) begin
          st_d = S_REPLY;
        end else if (tmo_hit) begin
          // Past the reader's wait the reply is worthless; drop it silently.
          st_d = S_IDLE;
        end
      end
      S_REPLY: begin
        if (tx_done) begin
          st_d = S_IDLE;
        end
      end
      default: begin
        st_d = S_IDLE;
      end
    endcase
  end

  urp_crc16 u_rx_crc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (rx.fsync),
    .en      (rx_take),
    .din     (rx.bit_val),
    .crc_q   (rx_crc)
  );

  urp_tx u_tx (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .load     (st_q == S_NVM && (nvm_done || nvm_err)),
    .is_err   (nvm_err),
    .handle   (ctx.handle),
    .err_code (urp_pkg::ERR_CODE_DEF),
    .bit_en   (bs_bit_en),
    .bs_q     (bs_q),
    .busy_q   (tx_busy),
    .done_q   (tx_done)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      armed_q <= 1'b0;
      len_q   <= 7'h00;
      sh_q    <= 80'h0;
    end else if (rx.fsync) begin
      armed_q <= 1'b1;
      len_q   <= 7'h00;
    end else if (rx.fend) begin
      armed_q <= 1'b0;
    end else if (rx_take) begin
      sh_q  <= {sh_q[78:0], rx.bit_val};
      len_q <= (len_q == urp_pkg::LEN_MAX) ? len_q : len_q + 7'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q      <= S_IDLE;
      set_q     <= 1'b0;
      ok_q      <= 1'b0;
      tmo_q     <= 19'h0;
      nvm_req_q <= 1'b0;
      nvm_val_q <= 1'b0;
      st_upd_q  <= 1'b0;
      st_next_q <= urp_pkg::G2_READY;
      busy_q    <= 1'b0;
    end else begin
      st_q      <= st_d;
      nvm_req_q <= dec_exec;
      st_upd_q  <= dec_upd;
      st_next_q <= dec_next;
      busy_q    <= (st_d != S_IDLE) || tx_busy;
      tmo_q     <= (st_q == S_NVM) ? tmo_q + 19'h1 : 19'h0;
      if (dec_exec) begin
        set_q     <= is_set;
        nvm_val_q <= is_set;
      end
      if (st_q == S_NVM && (nvm_done || nvm_err)) begin
        ok_q <= !nvm_err;
      end
    end
  end

  // Flags steer only the read path elsewhere; inventory keeps running.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      epc_hide_flag_q   <= urp_pkg::FLAG_RST;
      ident_hide_flag_q <= urp_pkg::FLAG_RST;
    end else if (cfg_load) begin
      epc_hide_flag_q   <= cfg_epc_hide;
      ident_hide_flag_q <= cfg_ident_hide;
    end else if (tx_done && ok_q) begin
      // Committed only once the last reply bit is out, so the reply itself is never hidden.
      epc_hide_flag_q   <= set_q;
      ident_hide_flag_q <= set_q;
    end
  end
endmodule

// ### src/urp_pkg.sv
// Shared constants and types for the read-hide command handler.
// Behaviour
// - Accepted set command raises both hide flags.
// - Hide flags only conceal reads, nothing else.
// - Zero access password: set command fully ignored; code ignores it in secured only, inventory states still fall back.
// - Set success reply: zero bit, handle, CRC.
// - Set takes effect after reply fully sent.
// - Internal failure backscatters an error code instead.
// - Replies always use extended preamble, TRext one.
// - Set frame: opcode e001, handle, CRC-16.
// - Set outside secured: silent, mapped next state.
// - Secured, good handle, bad password: arbitrate.
// - Secured good handle and password: reply, stay.
// - Accepted clear command resets both hide flags.
// - Clear password is access password XOR RN16 twice.
// - Clear frame: opcode e002, password, handle, CRC.
// - Clear success reply: zero bit, handle, CRC.
// - Clear in open/secured: reply, arbitrate or ignore.
package urp_pkg;

  typedef enum logic [2:0] {
    G2_READY     = 3'b000,
    G2_ARBITRATE = 3'b001,
    G2_REPLY     = 3'b010,
    G2_ACK       = 3'b011,
    G2_OPEN      = 3'b100,
    G2_SECURED   = 3'b101,
    G2_KILLED    = 3'b110
  } urp_g2_state_t;

  typedef struct packed {
    logic bit_val;
    logic valid;
    logic fsync;
    logic fend;
  } urp_rx_t;

  typedef struct packed {
    urp_g2_state_t state;
    logic [15:0]   handle;
    logic [15:0]   rn16;
    logic [31:0]   access_pw;
    logic          pw_auth;
  } urp_ctx_t;

  typedef struct packed {
    logic bit_val;
    logic valid;
    logic trext;
    logic last;
  } urp_bs_t;

  localparam logic [15:0] OP_SET       = 16'he001;
  localparam logic [15:0] OP_CLR       = 16'he002;
  localparam logic [6:0]  LEN_SET      = 7'h30;
  localparam logic [6:0]  LEN_CLR      = 7'h50;
  localparam logic [6:0]  LEN_MAX      = 7'h7f;
  localparam logic [15:0] CRC_INIT     = 16'hffff;
  localparam logic [15:0] CRC_POLY     = 16'h1021;
  localparam logic [15:0] CRC_RESIDUE  = 16'h1d0f;
  localparam logic [7:0]  ERR_CODE_DEF = 8'h0f;
  localparam logic [5:0]  TX_OK_BITS   = 6'h11;
  localparam logic [5:0]  TX_ERR_BITS  = 6'h19;
  localparam logic [5:0]  TX_CRC_BITS  = 6'h10;
  localparam logic        FLAG_RST     = 1'b0;
  localparam int          CLK_HZ       = 20000000;
  localparam int          REPLY_MS     = 20;
  localparam int          REPLY_CYC    = REPLY_MS * (CLK_HZ / 1000);

endpackage

// ### src/urp_crc16.sv
// Bit-serial CRC-16 register with the Gen2 polynomial.
`timescale 1ns/1ps
module urp_crc16 (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        en,
  input  wire logic        din,
  output logic [15:0]      crc_q
);
  wire        fb    = din ^ crc_q[15];
  wire [15:0] crc_d = {crc_q[14:0], 1'b0} ^ (fb ? urp_pkg::CRC_POLY : 16'h0000);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || clr) begin
      crc_q <= urp_pkg::CRC_INIT;
    end else if (en) begin
      crc_q <= crc_d;
    end
  end
endmodule

// ### src/urp_tx.sv
// Reply serialiser: header, payload and inverted CRC-16, one bit per enable.
`timescale 1ns/1ps
module urp_tx (
  input  wire logic           ref_clk,
  input  wire logic           rst_n,
  input  wire logic           load,
  input  wire logic           is_err,
  input  wire logic [15:0]    handle,
  input  wire logic [7:0]     err_code,
  input  wire logic           bit_en,
  output urp_pkg::urp_bs_t    bs_q,
  output logic                busy_q,
  output logic                done_q
);
  logic [24:0] sh_q;
  logic [5:0]  left_q;
  logic        crc_ph_q;
  logic [15:0] crc;

  wire step      = bit_en && busy_q;
  wire data_step = step && !crc_ph_q;
  wire last_bit  = (left_q == 6'h01);
  wire [3:0] crc_idx = 4'(left_q - 6'h01);

  urp_crc16 u_crc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clr     (load),
    .en      (data_step),
    .din     (sh_q[24]),
    .crc_q   (crc)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sh_q     <= 25'h0;
      left_q   <= 6'h00;
      crc_ph_q <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      bs_q     <= '0;
    end else begin
      done_q      <= 1'b0;
      bs_q.valid  <= 1'b0;
      bs_q.last   <= 1'b0;
      // The preamble marker must still stand while the last bit is out, so it drops one cycle later.
      bs_q.trext  <= bs_q.trext && !done_q;
      if (load) begin
        // Header bit is zero in both reply shapes.
        sh_q       <= is_err ? {1'b0, err_code, handle} : {1'b0, handle, 8'h00};
        left_q     <= is_err ? urp_pkg::TX_ERR_BITS : urp_pkg::TX_OK_BITS;
        crc_ph_q   <= 1'b0;
        busy_q     <= 1'b1;
        bs_q.trext <= 1'b1;
      end else if (step) begin
        bs_q.valid <= 1'b1;
        if (!crc_ph_q) begin
          bs_q.bit_val <= sh_q[24];
          sh_q         <= {sh_q[23:0], 1'b0};
          left_q       <= last_bit ? urp_pkg::TX_CRC_BITS : left_q - 6'h01;
          crc_ph_q     <= last_bit;
        end else begin
          // The CRC is sent inverted, as Gen2 replies require.
          bs_q.bit_val <= ~crc[crc_idx];
          left_q       <= left_q - 6'h01;
          if (last_bit) begin
            busy_q     <= 1'b0;
            done_q     <= 1'b1;
            bs_q.last  <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### dv/urp_cmd_properties.sv
// Port-level checks for the read-hide command interpreter.
`timescale 1ns/1ps
module urp_cmd_properties (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  urp_pkg::urp_rx_t       rx,
  input  urp_pkg::urp_ctx_t      ctx,
  input  wire logic              cfg_load,
  input  wire logic              cfg_epc_hide,
  input  wire logic              cfg_ident_hide,
  input  wire logic              nvm_done,
  input  wire logic              nvm_err,
  input  wire logic              bs_bit_en,
  input  wire logic              epc_hide_flag_q,
  input  wire logic              ident_hide_flag_q,
  input  wire logic              st_upd_q,
  input  urp_pkg::urp_g2_state_t st_next_q,
  input  wire logic              nvm_req_q,
  input  wire logic              nvm_val_q,
  input  urp_pkg::urp_bs_t       bs_q,
  input  wire logic              busy_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [5:0] nb_q;
  always_ff @(posedge ref_clk) begin
    nb_q <= bs_q.trext ? nb_q + {5'h00, bs_q.valid} : 6'h00;
  end
  sequence s_nvm; busy_q && (nvm_done || nvm_err); endsequence
  sequence s_tail; $past(bs_q.last) || $past(bs_q.last, 2) || $past(bs_q.last, 3); endsequence
  property p_load; s_nvm |=> bs_q.trext; endproperty
  a_load: assert property (p_load) else $error("reply did not start");
  property p_trext; bs_q.valid |-> bs_q.trext; endproperty
  a_trext: assert property (p_trext) else $error("short preamble used");
  property p_hdr; bs_q.valid && nb_q == 6'h00 |-> !bs_q.bit_val; endproperty
  a_hdr: assert property (p_hdr) else $error("header bit not zero");
  property p_len; bs_q.last |-> bs_q.valid && (nb_q == 6'h20 || nb_q == 6'h28); endproperty
  a_len: assert property (p_len) else $error("reply length wrong");
  property p_commit; $changed(epc_hide_flag_q) && !$past(cfg_load) |-> s_tail; endproperty
  a_commit: assert property (p_commit) else $error("flags moved before reply end");
  property p_both; $changed(epc_hide_flag_q) && !$past(cfg_load) |-> ident_hide_flag_q == epc_hide_flag_q; endproperty
  a_both: assert property (p_both) else $error("flags differ after command");
  property p_arb;
    st_upd_q |-> st_next_q == urp_pkg::G2_ARBITRATE && !(ctx.state inside {urp_pkg::G2_READY, urp_pkg::G2_KILLED});
  endproperty
  a_arb: assert property (p_arb) else $error("bad state request");
  property p_set; nvm_req_q && nvm_val_q |-> busy_q && ctx.state == urp_pkg::G2_SECURED && ctx.access_pw != 0; endproperty
  a_set: assert property (p_set) else $error("set accepted wrongly");
  property p_clr;
    nvm_req_q && !nvm_val_q |-> ctx.state inside {urp_pkg::G2_OPEN, urp_pkg::G2_SECURED};
  endproperty
  a_clr: assert property (p_clr) else $error("clear accepted wrongly");
  property p_dec; nvm_req_q |-> $past(rx.fend) || $past(rx.fend, 2); endproperty
  a_dec: assert property (p_dec) else $error("write not tied to frame end");
endmodule
bind urp_cmd urp_cmd_properties urp_cmd_properties_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .rx(rx), .ctx(ctx), .cfg_load(cfg_load), .cfg_epc_hide(cfg_epc_hide),
  .cfg_ident_hide(cfg_ident_hide), .nvm_done(nvm_done), .nvm_err(nvm_err), .bs_bit_en(bs_bit_en),
  .epc_hide_flag_q(epc_hide_flag_q), .ident_hide_flag_q(ident_hide_flag_q), .st_upd_q(st_upd_q),
  .st_next_q(st_next_q), .nvm_req_q(nvm_req_q), .nvm_val_q(nvm_val_q), .bs_q(bs_q), .busy_q(busy_q));

// ### dv/urp_reader.sv
// Reader model: frames commands onto the receive strobes and paces reply slots.
`timescale 1ns/1ps
module urp_reader (
  input  wire logic         ref_clk,
  output urp_pkg::urp_rx_t  rx,
  output logic              bs_bit_en,
  input  urp_pkg::urp_bs_t  bs_q
);
  int   slot = 3;
  int   cnt = 0;
  logic got[$];
  initial rx = '0;
  initial bs_bit_en = 1'b0;
  // Slots run on after each command, so the tag may answer at any moment.
  always @(negedge ref_clk) begin
    cnt = (cnt + 1) % slot;
    bs_bit_en = (cnt == 0);
  end
  always @(posedge ref_clk) begin
    if (bs_q.valid === 1'b1) got.push_back(bs_q.bit_val);
  end
  function automatic logic [15:0] crc16(input logic [79:0] v, input int n);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = n - 1; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ v[i]) ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic send(input logic [79:0] v, input int n, input bit bad);
    logic [15:0] c;
    c = ~crc16(v, n) ^ {15'h0000, bad};
    @(negedge ref_clk);
    rx.fsync = 1'b1;
    for (int i = n + 15; i >= 0; i--) begin
      @(negedge ref_clk);
      rx = '{(i > 15) ? v[i - 16] : c[i], 1'b1, 1'b0, 1'b0};
    end
    @(negedge ref_clk);
    rx = '{~rx.bit_val, 1'b0, 1'b0, 1'b1};
    @(negedge ref_clk);
    rx.fend = 1'b0;
  endtask
endmodule

// ### dv/tb_urp_cmd.sv
// Self-checking bench for the read-hide command interpreter.
`timescale 1ns/1ps
module tb_urp_cmd;
  logic                   ref_clk = 1'b0;
  logic                   rst_n = 1'b0;
  logic                   cfg_load = 1'b0;
  logic                   cfg_epc = 1'b0;
  logic                   cfg_ident = 1'b0;
  logic                   nvm_done = 1'b0;
  logic                   nvm_err = 1'b0;
  logic                   bs_bit_en;
  urp_pkg::urp_rx_t       rx;
  urp_pkg::urp_ctx_t      ctx = '0;
  urp_pkg::urp_bs_t       bs_q;
  urp_pkg::urp_g2_state_t st_next_q;
  urp_pkg::urp_g2_state_t upd_st;
  logic                   epc_q, ident_q, st_upd_q, nvm_req_q, nvm_val_q, busy_q;
  logic                   hide = 1'b1;
  int                     n_errors = 0;
  int                     n_tests = 0;
  int                     n_upd = 0;
  int                     n_req = 0;
  int                     seed = 21855;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (st_upd_q === 1'b1) upd_st = st_next_q;
    n_upd += (st_upd_q === 1'b1);
    n_req += (nvm_req_q === 1'b1);
  end
  urp_cmd #(.REPLY_CYC(64)) urp_cmd_inst (.ref_clk(ref_clk), .rst_n(rst_n), .rx(rx), .ctx(ctx),
    .cfg_load(cfg_load), .cfg_epc_hide(cfg_epc), .cfg_ident_hide(cfg_ident), .nvm_done(nvm_done), .nvm_err(nvm_err),
    .bs_bit_en(bs_bit_en), .epc_hide_flag_q(epc_q), .ident_hide_flag_q(ident_q), .st_upd_q(st_upd_q),
    .st_next_q(st_next_q), .nvm_req_q(nvm_req_q), .nvm_val_q(nvm_val_q), .bs_q(bs_q), .busy_q(busy_q));
  urp_reader urp_reader_inst (.ref_clk(ref_clk), .rx(rx), .bs_bit_en(bs_bit_en), .bs_q(bs_q));
  task automatic chk(input logic [79:0] got, input logic [79:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Resp 0 answers the write, 1 fails it, 2 leaves it to time out.
  task automatic run(input bit clr, input int st, input bit hok, pok, crc_ok, zpw, input int resp, slot);
    logic [79:0] v, x, g;
    logic [31:0] pw;
    logic [15:0] h;
    int          ex, u0, r0, k;
    h = 16'($random(seed));
    pw = zpw ? 32'h00000000 : 32'($random(seed)) | 32'h00000001;
    @(negedge ref_clk);
    ctx = '{urp_pkg::urp_g2_state_t'(st), h, 16'($random(seed)), pw, pok};
    if (clr) v = {16'h0000, urp_pkg::OP_CLR, pw ^ {ctx.rn16, ctx.rn16} ^ {31'h0, !pok}, h ^ {15'h0, !hok}};
    else v = {48'h0, urp_pkg::OP_SET, h ^ {15'h0, !hok}};
    // States 1 to 3 are arbitrate, reply and acknowledged.
    ex = (!crc_ok || (!clr && zpw)) ? 0 : (st == 5 || (clr && st == 4)) ? (hok ? (pok ? 2 : 1) : 0) :
         (st inside {[1:3]}) ? 1 : 0;
    if (ex != 2) resp = 2;
    u0 = n_upd;
    r0 = n_req;
    urp_reader_inst.got.delete();
    urp_reader_inst.slot = slot;
    urp_reader_inst.send(v, clr ? 64 : 32, !crc_ok);
    repeat (4) @(negedge ref_clk);
    chk(n_upd - u0, ex == 1, "state request");
    chk(n_req - r0, ex == 2, "config write");
    chk(busy_q, ex == 2, "busy");
    if (ex == 2) chk(nvm_val_q, !clr, "write value");
    if (ex == 1) chk(upd_st, urp_pkg::G2_ARBITRATE, "next state");
    nvm_done = (resp == 0);
    nvm_err = (resp == 1);
    @(negedge ref_clk);
    nvm_done = 1'b0;
    nvm_err = 1'b0;
    for (k = 0; k < 600 && busy_q !== 1'b0; k++) @(negedge ref_clk);
    repeat (3) @(negedge ref_clk);
    x = resp == 1 ? {55'h0, 1'b0, urp_pkg::ERR_CODE_DEF, h} : {63'h0, 1'b0, h};
    g = '0;
    foreach (urp_reader_inst.got[i]) g = {g[78:0], urp_reader_inst.got[i]};
    chk(urp_reader_inst.got.size(), resp == 2 ? 0 : (resp == 1 ? 41 : 33), "reply length");
    chk(g, resp == 2 ? 80'h0 : {x[63:0], ~urp_reader_inst.crc16(x, resp == 1 ? 25 : 17)}, "reply bits");
    if (resp == 0) hide = !clr;
    chk({epc_q, ident_q}, {hide, hide}, "hide flags");
    $display("test st=%0d clr=%0d done", st, clr);
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst_n = 1'b1;
    cfg_epc = 1'b1;
    cfg_ident = 1'($random(seed));
    cfg_load = 1'b1;
    @(negedge ref_clk);
    cfg_load = 1'b0;
    @(negedge ref_clk);
    chk({epc_q, ident_q}, {1'b1, cfg_ident}, "flag restore");
    run(0, 5, 1, 1, 1, 0, 0, 3);
    run(0, 5, 1, 1, 1, 0, 1, 2);
    run(1, 5, 1, 1, 1, 0, 0, 7);
    run(0, 5, 1, 1, 1, 0, 2, 3);
    run(0, 5, 1, 1, 0, 0, 0, 3);
    run(0, 5, 1, 1, 1, 1, 0, 3);
    run(0, 5, 0, 1, 1, 0, 0, 3);
    run(0, 5, 1, 0, 1, 0, 0, 3);
    for (int s = 0; s < 7; s++) begin
      run(0, s, 1, 1, 1, 0, 0, 2);
      run(1, s, 1, 1, 1, 0, 0, 5);
      run(1, s, 1, 0, 1, 0, 0, 2);
    end
    conclude();
  end
  initial begin
    #(40000 * 50);
    n_errors++;
    conclude();
  end
endmodule
